// file: rpi_panel.v
`timescale 1ns/1ps
`include "rpi_consts.vh"
module rpi_panel #(
    parameter NUM_ALARMS = `RPI_NUM_ALARMS,
    parameter NUM_FUNCS  = `RPI_NUM_FUNCS
) (
    input  wire                      clk,           // system clock
    input  wire                      rstn,          // async reset, active low
    input  wire                      ce,            // clock enable
    input  wire                      internal_fault, // relay self-check fault
    input  wire                      test_mode,     // relay in test mode
    input  wire [NUM_FUNCS-1:0]      pickup,        // per function pickup
    input  wire [NUM_FUNCS-1:0]      blocked,       // per function blocked
    input  wire [NUM_FUNCS-1:0]      func_reset,    // per function reset pulse
    input  wire [NUM_FUNCS-1:0]      trip,          // per function trip
    input  wire                      comm_reset,    // reset over communication
    input  wire                      clear_ind,     // clear indications pulse
    input  wire                      clear_alarms,  // acknowledge alarm lamps pulse
    input  wire [NUM_ALARMS-1:0]     alarm_act,     // alarm activation inputs
    input  wire                      eth_link,      // front port link up
    input  wire                      eth_traffic,   // front port traffic pulse
    input  wire [`RPI_REG_W-1:0]     addr,          // register address
    input  wire [31:0]               wdata,         // write data
    input  wire                      wr,            // write strobe
    input  wire                      rd,            // read strobe
    output reg  [31:0]               rdata,         // read data, cycle after rd
    output reg                       lamp_healthy,  // healthy lamp
    output reg                       lamp_pickup,   // pickup lamp
    output reg                       lamp_trip,     // trip lamp
    output reg  [NUM_ALARMS-1:0]     lamp_alarm,    // alarm lamps
    output reg                       lamp_link,     // green link lamp
    output reg                       lamp_activity, // yellow activity lamp
    output reg                       msg_fault,     // fault message request
    output reg                       msg_pickup,    // pickup message request
    output reg                       msg_trip,      // trip message request
    output reg  [`RPI_ID_W-1:0]      last_pickup_id, // most recent pickup function
    output reg  [`RPI_ID_W-1:0]      last_trip_id,  // most recent trip function
    output reg                       web_enabled    // active browser interface state
);

////////////////////////////////////////////////////////////////////////////////
reg rst_s1;
reg rst_s2;
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        rst_s1 <= 1'b0;
        rst_s2 <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_s2 <= rst_s1;
    end
end
wire rst_n = rst_s2;

////////////////////////////////////////////////////////////////////////////////
// blink timebase shared by every flashing lamp keeps them in phase
reg [`RPI_BLINK_W-1:0] blink_cnt;
reg                    blink;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        blink_cnt <= {`RPI_BLINK_W{1'b0}};
        blink     <= 1'b0;
    end else if (ce) begin
        if (blink_cnt == `RPI_BLINK_HALF) begin
            blink_cnt <= {`RPI_BLINK_W{1'b0}};
            blink     <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// registers
reg                      web_cfg;
reg [2*NUM_ALARMS-1:0]   alarm_mode;
reg [`RPI_SET_W-1:0]     set_val;
reg [`RPI_SET_W-1:0]     set_min;
reg [`RPI_SET_W-1:0]     set_max;
reg                      set_invalid;
reg                      ack_sw;
wire [31:0]              mode_word = {{(32-2*NUM_ALARMS){1'b0}}, alarm_mode};
wire                     ack = clear_alarms | ack_sw;
wire [`RPI_SET_W-1:0]    wval = wdata[`RPI_SET_W-1:0];

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        web_cfg     <= 1'b1;
        alarm_mode  <= {(2*NUM_ALARMS){1'b0}};
        set_val     <= `RPI_SET_MIN_RST;
        set_min     <= `RPI_SET_MIN_RST;
        set_max     <= `RPI_SET_MAX_RST;
        set_invalid <= 1'b0;
        ack_sw      <= 1'b0;
    end else if (ce) begin
        ack_sw <= 1'b0;
        if (wr) begin
            case (addr)
            `RPI_OFF_CTRL: begin
                web_cfg <= wdata[`RPI_BIT_WEB_EN];
            end
            `RPI_OFF_MODE_LO: begin
                alarm_mode[15:0] <= wdata[15:0];
            end
            `RPI_OFF_MODE_HI: begin
                alarm_mode[2*NUM_ALARMS-1:16] <= wdata[2*NUM_ALARMS-17:0];
            end
            `RPI_OFF_SET_VAL: begin
                // out of range values are refused and flagged
                if (wval < set_min || wval > set_max) begin
                    set_invalid <= 1'b1;
                end else begin
                    set_val     <= wval;
                    set_invalid <= 1'b0;
                end
            end
            `RPI_OFF_SET_MIN: begin
                set_min <= wval;
            end
            `RPI_OFF_SET_MAX: begin
                set_max <= wval;
            end
            `RPI_OFF_ACK: begin
                ack_sw <= wdata[0];
            end
            default: begin
            end
            endcase
        end
    end
end

// web enable is sampled only when reset is released, i.e. at restart
reg rst_live;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        web_enabled <= 1'b1;
    end else if (ce && !rst_live) begin
        web_enabled <= web_cfg;
    end
end
// marks that the first cycle after restart has passed
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        rst_live <= 1'b0;
    end else if (ce && rst_n) begin
        rst_live <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// protection indicators
reg                 trip_latch;
reg [NUM_FUNCS-1:0] pickup_d;
reg [NUM_FUNCS-1:0] trip_d;
reg [NUM_FUNCS-1:0] blk_hold;
reg [NUM_FUNCS-1:0] blk_seen;
wire [NUM_FUNCS-1:0] pickup_rise = pickup & ~pickup_d;
wire [NUM_FUNCS-1:0] trip_rise   = trip & ~trip_d;
wire [NUM_FUNCS-1:0] next_blk    = blocked & ~func_reset & (blk_hold | blocked & ~blk_seen);
wire                 any_block   = |next_blk;
wire                 trip_clr    = comm_reset | clear_ind;
// new trip wins over a clear in the same cycle
wire                 next_trip_latch = (|trip) | (trip_latch & ~trip_clr);

reg [`RPI_ID_W-1:0] next_pick_id;
reg [`RPI_ID_W-1:0] next_trip_id;
integer i;
always @* begin
    next_pick_id = last_pickup_id;
    next_trip_id = last_trip_id;
    for (i = 0; i < NUM_FUNCS; i = i + 1) begin
        if (pickup_rise[i]) begin
            next_pick_id = i[`RPI_ID_W-1:0];
        end
        if (trip_rise[i]) begin
            next_trip_id = i[`RPI_ID_W-1:0];
        end
    end
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        trip_latch   <= 1'b0;
        pickup_d     <= {NUM_FUNCS{1'b0}};
        trip_d       <= {NUM_FUNCS{1'b0}};
        blk_hold     <= {NUM_FUNCS{1'b0}};
        blk_seen     <= {NUM_FUNCS{1'b0}};
        lamp_healthy <= 1'b0;
        lamp_pickup  <= 1'b0;
        lamp_trip    <= 1'b0;
    end else if (ce) begin
        pickup_d     <= pickup;
        trip_d       <= trip;
        // a function reset drops the blocked indication until blocking re-asserts
        blk_hold     <= next_blk;
        blk_seen     <= blocked;
        trip_latch   <= next_trip_latch;
        lamp_healthy <= (internal_fault | test_mode) ? blink : 1'b1;
        if (any_block) begin
            lamp_pickup <= blink;
        end else begin
            lamp_pickup <= |pickup;
        end
        // lamp follows the next latch value so it never lags a clear by a cycle
        lamp_trip    <= next_trip_latch;
    end
end

// identity of the most recent pickup and trip shown on the display
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        last_pickup_id <= {`RPI_ID_W{1'b0}};
        last_trip_id   <= {`RPI_ID_W{1'b0}};
    end else if (ce) begin
        last_pickup_id <= next_pick_id;
        last_trip_id   <= next_trip_id;
    end
end

// message requests; a test mode flash alone raises no fault message
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        msg_fault  <= 1'b0;
        msg_pickup <= 1'b0;
        msg_trip   <= 1'b0;
    end else if (ce) begin
        msg_fault  <= internal_fault;
        msg_pickup <= |pickup;
        msg_trip   <= next_trip_latch;
    end
end

////////////////////////////////////////////////////////////////////////////////
// alarm lamps; pending set wins over an acknowledge in the same cycle
reg [NUM_ALARMS-1:0] pend;
reg [NUM_ALARMS-1:0] acked;
genvar g;
generate
    for (g = 0; g < NUM_ALARMS; g = g + 1) begin : g_alarm
        wire [1:0] mode = alarm_mode[2*g+1:2*g];
        always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pend[g]       <= 1'b0;
                acked[g]      <= 1'b0;
                lamp_alarm[g] <= 1'b0;
            end else if (ce) begin
                // an alarm acknowledged while active leaves nothing pending after release
                if (alarm_act[g] && !acked[g]) begin
                    pend[g] <= 1'b1;
                end else if (ack || acked[g]) begin
                    pend[g] <= 1'b0;
                end
                if (!alarm_act[g]) begin
                    acked[g] <= 1'b0;
                end else if (ack) begin
                    acked[g] <= 1'b1;
                end
                case (mode)
                `RPI_MODE_NL: begin
                    lamp_alarm[g] <= alarm_act[g];
                end
                `RPI_MODE_LT: begin
                    lamp_alarm[g] <= alarm_act[g] | pend[g];
                end
                `RPI_MODE_NLF: begin
                    lamp_alarm[g] <= alarm_act[g] & blink;
                end
                `RPI_MODE_LTF: begin
                    if (alarm_act[g] && acked[g]) begin
                        lamp_alarm[g] <= 1'b1;
                    end else begin
                        lamp_alarm[g] <= (alarm_act[g] | pend[g]) & blink;
                    end
                end
                default: begin
                    lamp_alarm[g] <= 1'b0;
                end
                endcase
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// front port lamps; activity stretched so short traffic bursts stay visible
reg [`RPI_BLINK_W-1:0] act_cnt;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        act_cnt       <= {`RPI_BLINK_W{1'b0}};
        lamp_link     <= 1'b0;
        lamp_activity <= 1'b0;
    end else if (ce) begin
        lamp_link <= eth_link;
        if (eth_traffic) begin
            act_cnt <= `RPI_ACT_HALF;
        end else if (act_cnt != {`RPI_BLINK_W{1'b0}}) begin
            act_cnt <= act_cnt - 1'b1;
        end
        lamp_activity <= (act_cnt != {`RPI_BLINK_W{1'b0}}) & blink;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read port
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rdata <= 32'h0;
    end else if (ce) begin
        rdata <= 32'h0;
        if (rd) begin
            case (addr)
            `RPI_OFF_CTRL: begin
                rdata <= {31'h0, web_cfg};
            end
            `RPI_OFF_STATUS: begin
                rdata <= {29'h0, set_invalid, web_enabled, trip_latch};
            end
            `RPI_OFF_MODE_LO: begin
                rdata <= {16'h0, mode_word[15:0]};
            end
            `RPI_OFF_MODE_HI: begin
                rdata <= {16'h0, mode_word[31:16]};
            end
            `RPI_OFF_LAMPS: begin
                rdata <= {18'h0, lamp_link, lamp_activity, lamp_alarm[10:0], lamp_trip};
            end
            `RPI_OFF_SET_VAL: begin
                rdata <= {16'h0, set_val};
            end
            `RPI_OFF_SET_MIN: begin
                rdata <= {16'h0, set_min};
            end
            `RPI_OFF_SET_MAX: begin
                rdata <= {16'h0, set_max};
            end
            default: begin
                rdata <= 32'h0;
            end
            endcase
        end
    end
end

endmodule

// file: rpi_consts.vh
`ifndef RPI_CONSTS_VH
`define RPI_CONSTS_VH
`define RPI_NUM_ALARMS     11
`define RPI_NUM_FUNCS      8
`define RPI_ID_W           3
`define RPI_BLINK_W        24
`define RPI_BLINK_HALF     24'h7735a0
`define RPI_ACT_HALF       24'h1e8480
`define RPI_SET_W          16
`define RPI_REG_W          4
`define RPI_OFF_CTRL       4'h0
`define RPI_OFF_STATUS     4'h1
`define RPI_OFF_MODE_LO    4'h2
`define RPI_OFF_MODE_HI    4'h3
`define RPI_OFF_LAMPS      4'h4
`define RPI_OFF_SET_VAL    4'h5
`define RPI_OFF_SET_MIN    4'h6
`define RPI_OFF_SET_MAX    4'h7
`define RPI_OFF_ACK        4'h8
`define RPI_BIT_WEB_EN     0
`define RPI_MODE_NL        2'h0
`define RPI_MODE_LT        2'h1
`define RPI_MODE_NLF       2'h2
`define RPI_MODE_LTF       2'h3
`define RPI_SET_MIN_RST    16'h0000
`define RPI_SET_MAX_RST    16'hffff
`endif

// file: rpi_panel_asserts.sv
`timescale 1ns/1ps
`include "rpi_consts.vh"
module rpi_panel_asserts #(
    parameter NUM_ALARMS = 11,
    parameter NUM_FUNCS  = 8
) (
    input wire                 clk,            // clock
    input wire                 rstn,           // reset
    input wire                 ce,             // enable
    input wire                 internal_fault, // fault
    input wire                 test_mode,      // test
    input wire [NUM_FUNCS-1:0] pickup,         // pickups
    input wire [NUM_FUNCS-1:0] blocked,        // blocks
    input wire [NUM_FUNCS-1:0] trip,           // trips
    input wire                 comm_reset,     // comm clear
    input wire                 clear_ind,      // panel clear
    input wire                 eth_link,       // link
    input wire                 rd,             // read strobe
    input wire [31:0]          rdata,          // read data
    input wire                 lamp_healthy,   // lamp
    input wire                 lamp_pickup,    // lamp
    input wire                 lamp_trip,      // lamp
    input wire                 lamp_link,      // lamp
    input wire                 msg_fault,      // message
    input wire                 msg_pickup,     // message
    input wire [`RPI_ID_W-1:0] last_pickup_id, // id
    input wire [`RPI_ID_W-1:0] last_trip_id    // id
);
////////////////////////////////////////////////////////////
// reset copy inside the design lags, so hold off checks
reg [1:0]           cnt;
reg [NUM_FUNCS-1:0] prev_pu;
reg [NUM_FUNCS-1:0] prev_tr;
reg [`RPI_ID_W-1:0] e_pu;
reg [`RPI_ID_W-1:0] e_tr;
wire                live = (cnt == 2'h3);
function [`RPI_ID_W-1:0] f_hi(input [NUM_FUNCS-1:0] v);
    integer i;
    begin
        f_hi = {`RPI_ID_W{1'b0}};
        for (i = 0; i < NUM_FUNCS; i = i + 1)
            if (v[i]) f_hi = i[`RPI_ID_W-1:0];
    end
endfunction
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        cnt <= 2'h0;
        prev_pu <= 0;
        prev_tr <= 0;
        e_pu <= 0;
        e_tr <= 0;
    end else begin
        if (!live) cnt <= cnt + 2'h1;
        if (ce) begin
            prev_pu <= pickup;
            prev_tr <= trip;
            e_pu <= f_hi(pickup & ~prev_pu);
            e_tr <= f_hi(trip & ~prev_tr);
        end
    end
end
////////////////////////////////////////////////////////////
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
sequence s_go; live && ce; endsequence
sequence s_new_tr; s_go ##0 ((trip & ~prev_tr) != 0); endsequence
sequence s_new_pu; s_go ##0 ((pickup & ~prev_pu) != 0); endsequence
property p_healthy; s_go ##0 (!internal_fault && !test_mode) |=> lamp_healthy; endproperty
property p_msg_fault; s_go |=> msg_fault == $past(internal_fault); endproperty
property p_pu_on; s_go ##0 (pickup != 0 && blocked == 0) |=> lamp_pickup && msg_pickup; endproperty
property p_pu_off; s_go ##0 (pickup == 0 && blocked == 0) |=> !lamp_pickup; endproperty
property p_trip_set; s_go ##0 (trip != 0) |=> lamp_trip; endproperty
property p_trip_hold; s_go ##0 (lamp_trip && !comm_reset && !clear_ind) |=> lamp_trip; endproperty
property p_trip_clr; s_go ##0 (trip == 0 && (comm_reset || clear_ind)) |=> !lamp_trip; endproperty
property p_trip_id; s_new_tr |=> last_trip_id == e_tr; endproperty
property p_pu_id; s_new_pu |=> last_pickup_id == e_pu; endproperty
property p_link; s_go |=> lamp_link == $past(eth_link); endproperty
property p_rdata; s_go ##0 !rd |=> rdata == 32'h0; endproperty
a_healthy: assert property (p_healthy) else $error("healthy lamp not steady");
a_msg_fault: assert property (p_msg_fault) else $error("fault message wrong");
a_pu_on: assert property (p_pu_on) else $error("pickup lamp or message off");
a_pu_off: assert property (p_pu_off) else $error("pickup lamp lit when idle");
a_trip_set: assert property (p_trip_set) else $error("trip lamp not lit");
a_trip_hold: assert property (p_trip_hold) else $error("trip lamp dropped");
a_trip_clr: assert property (p_trip_clr) else $error("trip lamp not cleared");
a_trip_id: assert property (p_trip_id) else $error("trip id wrong");
a_pu_id: assert property (p_pu_id) else $error("pickup id wrong");
a_link: assert property (p_link) else $error("link lamp wrong");
a_rdata: assert property (p_rdata) else $error("read data not idle");
endmodule
bind rpi_panel rpi_panel_asserts #(.NUM_ALARMS(NUM_ALARMS), .NUM_FUNCS(NUM_FUNCS)) rpi_panel_asserts_inst (
    .clk, .rstn, .ce, .internal_fault, .test_mode, .pickup, .blocked, .trip, .comm_reset, .clear_ind,
    .eth_link, .rd, .rdata, .lamp_healthy, .lamp_pickup, .lamp_trip, .lamp_link, .msg_fault,
    .msg_pickup, .last_pickup_id, .last_trip_id);

// file: rpi_pm.sv
`timescale 1ns/1ps
module rpi_pm (
    input wire  clk,            // clock
    output reg  internal_fault, // fault
    output reg  test_mode,      // test
    output reg  [7:0] pickup,   // pickups
    output reg  [7:0] blocked,  // blocks
    output reg  [7:0] func_reset, // resets
    output reg  [7:0] trip,     // trips
    output reg  comm_reset,     // comm clear
    output reg  clear_ind,      // first press
    output reg  clear_alarms,   // second press
    output reg  eth_link,       // link
    output reg  eth_traffic     // traffic
);
initial {internal_fault, test_mode, pickup, blocked, func_reset, trip} = 0;
initial {comm_reset, clear_ind, clear_alarms, eth_link, eth_traffic} = 0;
// press timing is abstracted to one pulse per press
task press_clear;
    begin
        @(posedge clk) clear_ind <= 1'b1;
        @(posedge clk) clear_ind <= 1'b0;
        clear_alarms <= 1'b1;
        @(posedge clk) clear_alarms <= 1'b0;
    end
endtask
task comm_pulse;
    begin
        @(posedge clk) comm_reset <= 1'b1;
        @(posedge clk) comm_reset <= 1'b0;
    end
endtask
task reset_func(input [7:0] m);
    begin
        @(posedge clk) func_reset <= m;
        @(posedge clk) func_reset <= 8'h00;
    end
endtask
endmodule

// file: rpi_panel_tb_top.sv
`timescale 1ns/1ps
`include "rpi_consts.vh"
module rpi_panel_tb_top;
reg clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
reg [3:0] addr = 4'h0;
reg [31:0] wdata = 32'h0;
reg [10:0] act = 11'h000;
wire f, tm, cr, ci, ca, el, et;
wire [7:0] pu, bl, fr, tr;
wire [31:0] rdata;
wire lh, lp, lt, ll, la, mf, mp, mt, we;
wire [10:0] lal;
wire [2:0] pid, tid;
integer n_errors = 0, n_compared = 0;
always #2 clk = ~clk;
rpi_pm rpi_pm_inst (.clk(clk), .internal_fault(f), .test_mode(tm), .pickup(pu), .blocked(bl),
    .func_reset(fr), .trip(tr), .comm_reset(cr), .clear_ind(ci), .clear_alarms(ca), .eth_link(el),
    .eth_traffic(et));
rpi_panel rpi_panel_inst (.clk(clk), .rstn(rstn), .ce(ce), .internal_fault(f), .test_mode(tm),
    .pickup(pu), .blocked(bl), .func_reset(fr), .trip(tr), .comm_reset(cr), .clear_ind(ci),
    .clear_alarms(ca), .alarm_act(act), .eth_link(el), .eth_traffic(et), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .lamp_healthy(lh), .lamp_pickup(lp), .lamp_trip(lt),
    .lamp_alarm(lal), .lamp_link(ll), .lamp_activity(la), .msg_fault(mf), .msg_pickup(mp),
    .msg_trip(mt), .last_pickup_id(pid), .last_trip_id(tid), .web_enabled(we));
////////////////////////////////////////////////////////////
task chk(input [31:0] g, input [31:0] e);
    begin
        n_compared = n_compared + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    end
endtask
task tick(input integer n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
endtask
task wr_reg(input [3:0] a, input [31:0] d);
    begin
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    end
endtask
task rd_reg(input [3:0] a, input [31:0] e);
    begin
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata, e);
    end
endtask
// st: 0 active, 1 released unacked, 2 idle, 3 active acked; lamp i has mode i%4
function [10:0] exp_al(input [1:0] st, input b);
    integer i;
    reg [1:0] m;
    begin
        for (i = 0; i < 11; i = i + 1) begin
            m = i[1:0];
            case (st)
                2'h0: exp_al[i] = m[1] ? b : 1'b1;
                2'h1: exp_al[i] = (m == 2'h1) | ((m == 2'h3) & b);
                2'h2: exp_al[i] = 1'b0;
                default: exp_al[i] = (m == 2'h2) ? b : 1'b1;
            endcase
        end
    end
endfunction
task end_sim;
    begin
        $display("compared=%0d errors=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
endtask
initial begin
    #200000 n_errors = n_errors + 1;
    end_sim;
end
////////////////////////////////////////////////////////////
initial begin
    tick(2);
    rstn <= 1'b1;
    tick(4);
    chk(lh, 1);
    chk(we, 1);
    rd_reg(`RPI_OFF_CTRL, 32'h1);
    rd_reg(`RPI_OFF_SET_MIN, 32'h0);
    rd_reg(`RPI_OFF_SET_MAX, 32'hffff);
    rd_reg(4'hf, 32'h0);
    $display("reset test done");
    @(posedge clk) rpi_pm_inst.trip <= 8'h04;
    @(posedge clk) rpi_pm_inst.trip <= 8'h24;
    @(posedge clk) rpi_pm_inst.trip <= 8'h00;
    tick(2);
    chk(tid, 5);
    chk({lt, mt}, 2'h3);
    rpi_pm_inst.comm_pulse;
    tick(2);
    chk({lt, mt}, 2'h0);
    @(posedge clk) rpi_pm_inst.pickup <= 8'h02;
    @(posedge clk) rpi_pm_inst.pickup <= 8'h42;
    tick(2);
    chk(pid, 6);
    chk({lp, mp}, 2'h3);
    @(posedge clk) {rpi_pm_inst.internal_fault, rpi_pm_inst.blocked} <= {1'b1, 8'h01};
    tick(2);
    chk(mf, 1);
    chk(lp, lh);
    @(posedge clk) rpi_pm_inst.blocked <= 8'h00;
    tick(2);
    chk(lp, 1);
    @(posedge clk) rpi_pm_inst.blocked <= 8'h01;
    rpi_pm_inst.reset_func(8'h01);
    tick(2);
    chk(lp, 1);
    @(posedge clk) {rpi_pm_inst.internal_fault, rpi_pm_inst.test_mode} <= 2'b01;
    {rpi_pm_inst.blocked, rpi_pm_inst.pickup} <= 16'h0;
    tick(2);
    chk({mf, lp}, 0);
    $display("protection test done");
    wr_reg(`RPI_OFF_MODE_LO, 32'h0000e4e4);
    wr_reg(`RPI_OFF_MODE_HI, 32'h00000024);
    @(posedge clk) act <= 11'h7ff;
    tick(2);
    chk(lal, exp_al(0, lh));
    @(posedge clk) act <= 11'h000;
    tick(2);
    chk(lal, exp_al(1, lh));
    wr_reg(`RPI_OFF_ACK, 32'h1);
    tick(2);
    chk(lal, exp_al(2, lh));
    @(posedge clk) act <= 11'h7ff;
    rpi_pm_inst.press_clear;
    tick(2);
    chk(lal, exp_al(3, lh));
    @(posedge clk) act <= 11'h000;
    rpi_pm_inst.press_clear;
    tick(2);
    chk(lal, exp_al(2, lh));
    $display("alarm test done");
    wr_reg(`RPI_OFF_SET_MIN, 32'h10);
    wr_reg(`RPI_OFF_SET_MAX, 32'h20);
    wr_reg(`RPI_OFF_SET_VAL, 32'h15);
    rd_reg(`RPI_OFF_SET_VAL, 32'h15);
    wr_reg(`RPI_OFF_SET_VAL, 32'h30);
    rd_reg(`RPI_OFF_SET_VAL, 32'h15);
    rd_reg(`RPI_OFF_STATUS, 32'h6);
    wr_reg(`RPI_OFF_SET_VAL, 32'h20);
    rd_reg(`RPI_OFF_STATUS, 32'h2);
    wr_reg(`RPI_OFF_CTRL, 32'h0);
    rd_reg(`RPI_OFF_CTRL, 32'h0);
    chk(we, 1);
    $display("register test done");
    @(posedge clk) {rpi_pm_inst.eth_link, rpi_pm_inst.eth_traffic, rpi_pm_inst.test_mode} <= 3'b110;
    @(posedge clk) rpi_pm_inst.eth_traffic <= 1'b0;
    tick(2);
    chk({ll, lh}, 2'h3);
    @(posedge clk) {ce, rpi_pm_inst.eth_link} <= 2'b00;
    tick(2);
    chk(ll, 1);
    @(posedge clk) ce <= 1'b1;
    tick(2);
    chk(ll, 0);
    $display("port test done");
    end_sim;
end
endmodule
